// file: pkg/sube_pkg.sv
// Package: constants and types of the subtract execution block
// Summary of operation
// - Literal subtract 0000 1000 kkkk kkkk puts literal minus accumulator into accumulator.
// - File subtract 0101 11da ffff ffff computes register minus accumulator, two's complement.
// - File subtract with d=0 writes accumulator, source register untouched.
// - File subtract with d=1 writes the difference back to the register.
// - Access bit 0 maps the file address into the access bank.
// - Access bit 1 takes the bank from the bank select register.
// - Extended set, access bit 0, address up to 5Fh: indexed literal offset.
// - Literal subtract: one word, one cycle; decode, read literal, process, write accumulator.
// - File subtract: one word, one cycle; decode, read, process, write destination.
// - Both update negative, overflow, carry, nibble, zero flags; carry inverted borrow, negative is sign.
// - Zero result sets zero flag and carry.
// - Positive nonzero result sets carry, clears zero and negative.
package sube_pkg;
   // Opcodes and instruction fields
   localparam logic [7:0] OPC_LIT = 8'h08;
   localparam logic [5:0] OPC_FILE = 6'h17;
   localparam int BIT_DEST = 9;
   localparam int BIT_ACCESS = 8;
   localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_INSTR = 8'h04;
   localparam logic [7:0] REG_ACC = 8'h08;
   localparam logic [7:0] REG_BANK = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_IDX_BASE = 8'h14;
   localparam logic [7:0] REG_RAM_ADDR = 8'h18;
   localparam logic [7:0] REG_RAM_DATA = 8'h1C;
   // Field positions
   localparam int CTRL_EXT_EN = 0;
   localparam int ST_BUSY = 5;
   localparam int ST_REJECT = 6;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Reset values
   localparam logic [7:0] RST_ACC = 8'h00;
   localparam logic [3:0] RST_BANK = 4'h0;
   localparam logic RST_EXT_EN = 1'b0;
   localparam logic [11:0] RST_IDX_BASE = 12'h000;

   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_ONE = 3'b001,
      PH_TWO = 3'b010,
      PH_THREE = 3'b011,
      PH_FOUR = 3'b100
   } sube_phase_e;

   // Flag order gives status bits 4..0 as negative, overflow, zero, nibble, carry
   typedef struct packed {
      logic n;
      logic signed_overflow_flag;
      logic z;
      logic nibble_borrow_flag;
      logic c;
   } sube_flags_s;

   typedef struct packed {
      sube_phase_e ph;
      logic [15:0] instr;
      logic [7:0] acc;
      logic [3:0] bank;
      logic ext_en;
      logic [11:0] idx_base;
      logic [11:0] ram_addr;
      sube_flags_s flags;
      logic reject;
      logic [7:0] opnd;
      logic [7:0] res;
      sube_flags_s res_flags;
      logic [11:0] ex_addr;
      logic aw_held;
      logic [7:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sube_state_s;

   localparam sube_state_s STATE_RST = '{
      ph: PH_IDLE,
      acc: RST_ACC,
      bank: RST_BANK,
      ext_en: RST_EXT_EN,
      idx_base: RST_IDX_BASE,
      default: '0
   };
endpackage

// file: hw/sube_file_ram.sv
// File register memory with a registered read port
`timescale 1ns/1ps
`default_nettype none
module sube_file_ram (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Read port
   input wire logic [11:0] rd_addr,
   output logic [7:0] rd_data,
   // Write port
   input wire logic we,
   input wire logic [11:0] wr_addr,
   input wire logic [7:0] wr_data
);
   logic [7:0] mem [0:4095];
   logic [7:0] rd_data_ff;

   always_ff @(posedge clk) begin
      if (we) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data_ff <= 8'h00;
      end else begin
         rd_data_ff <= mem[rd_addr];
      end
   end

   assign rd_data = rd_data_ff;
endmodule
`default_nettype wire

// file: hw/sube_core.sv
// Subtract execution core with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module sube_core (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Write address channel
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // Write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read address channel
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // Read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Execution status
   output logic busy,
   output logic phase_one
);
   sube_pkg::sube_state_s q_ff;
   sube_pkg::sube_state_s nxt_q;
   logic [7:0] ram_rdata;
   logic ram_we;
   logic [11:0] ram_raddr;
   logic [11:0] ram_waddr;
   logic [7:0] ram_wdata;
   logic is_lit;
   logic is_file;
   logic dest_file;
   logic access_sel;
   logic indexed;
   logic [7:0] f_addr;
   logic [11:0] ex_addr_c;
   logic [8:0] diff9;
   logic [4:0] diff_lo;
   sube_pkg::sube_flags_s flags_c;
   logic wr_go;
   logic [32:0] old_full;
   logic [32:0] rd_full;
   logic [31:0] old_word;
   logic [31:0] wmerged;
   logic [31:0] rd_word;
   logic rd_ok;
   logic new_legal;

   // Register view of one offset
   function automatic logic [32:0] reg_word(input logic [7:0] a);
      logic [32:0] w;
      w = {1'b1, 32'h0000_0000};
      unique case (a)
         sube_pkg::REG_CTRL: w[31:0] = {31'h0000_0000, q_ff.ext_en};
         sube_pkg::REG_INSTR: w[31:0] = {16'h0000, q_ff.instr};
         sube_pkg::REG_ACC: w[31:0] = {24'h00_0000, q_ff.acc};
         sube_pkg::REG_BANK: w[31:0] = {28'h000_0000, q_ff.bank};
         sube_pkg::REG_STATUS: w[31:0] = {25'h000_0000, q_ff.reject, busy, q_ff.flags};
         sube_pkg::REG_IDX_BASE: w[31:0] = {20'h0_0000, q_ff.idx_base};
         sube_pkg::REG_RAM_ADDR: w[31:0] = {20'h0_0000, q_ff.ram_addr};
         sube_pkg::REG_RAM_DATA: w[31:0] = {24'h00_0000, ram_rdata};
         default: w[32] = 1'b0;
      endcase
      return w;
   endfunction

   // Instruction decode
   assign is_lit = (q_ff.instr[15:8] == sube_pkg::OPC_LIT);
   assign is_file = (q_ff.instr[15:10] == sube_pkg::OPC_FILE);
   assign dest_file = q_ff.instr[sube_pkg::BIT_DEST];
   assign access_sel = ~q_ff.instr[sube_pkg::BIT_ACCESS];
   assign f_addr = q_ff.instr[7:0];
   assign indexed = is_file && access_sel && q_ff.ext_en && (f_addr <= sube_pkg::ACCESS_LIMIT);

   // Operand address
   always_comb begin
      if (indexed) begin
         ex_addr_c = 12'(q_ff.idx_base + {4'h0, f_addr});
      end else if (access_sel) begin
         if (f_addr <= sube_pkg::ACCESS_LIMIT) begin
            ex_addr_c = {sube_pkg::ACCESS_LO_BANK, f_addr};
         end else begin
            ex_addr_c = {sube_pkg::ACCESS_HI_BANK, f_addr};
         end
      end else begin
         ex_addr_c = {q_ff.bank, f_addr};
      end
   end

   // Difference and flags
   assign diff9 = {1'b0, q_ff.opnd} - {1'b0, q_ff.acc};
   assign diff_lo = {1'b0, q_ff.opnd[3:0]} - {1'b0, q_ff.acc[3:0]};
   always_comb begin
      flags_c.n = diff9[7];
      flags_c.c = ~diff9[8];
      flags_c.z = (diff9[7:0] == 8'h00);
      flags_c.nibble_borrow_flag = ~diff_lo[4];
      flags_c.signed_overflow_flag = (q_ff.opnd[7] ^ q_ff.acc[7]) & (diff9[7] ^ q_ff.opnd[7]);
   end

   // Bus side helpers
   assign wr_go = q_ff.aw_held && q_ff.w_held && !q_ff.bvalid && (q_ff.ph == sube_pkg::PH_IDLE);
   // Procedural so that the register view follows every state it reads
   always_comb begin
      old_full = reg_word(q_ff.awaddr);
      rd_full = reg_word(s_axi_araddr);
   end
   assign old_word = old_full[31:0];
   for (genvar i = 0; i < 4; i++) begin : g_lane
      assign wmerged[8*i +: 8] = q_ff.wstrb[i] ? q_ff.wdata[8*i +: 8] : old_word[8*i +: 8];
   end
   assign rd_word = rd_full[31:0];
   assign rd_ok = rd_full[32];
   assign new_legal = (wmerged[15:8] == sube_pkg::OPC_LIT) || (wmerged[15:10] == sube_pkg::OPC_FILE);
   assign ram_raddr = (q_ff.ph == sube_pkg::PH_ONE) ? ex_addr_c : q_ff.ram_addr;

   always_comb begin
      nxt_q = q_ff;
      ram_we = 1'b0;
      ram_waddr = q_ff.ex_addr;
      ram_wdata = q_ff.res;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_q.aw_held = 1'b1;
         nxt_q.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_q.w_held = 1'b1;
         nxt_q.wdata = s_axi_wdata;
         nxt_q.wstrb = s_axi_wstrb;
      end
      if (q_ff.bvalid && s_axi_bready) begin
         nxt_q.bvalid = 1'b0;
      end
      // Register writes wait for the core to be idle
      if (wr_go) begin
         nxt_q.aw_held = 1'b0;
         nxt_q.w_held = 1'b0;
         nxt_q.bvalid = 1'b1;
         nxt_q.bresp = sube_pkg::RESP_OKAY;
         unique case (q_ff.awaddr)
            sube_pkg::REG_CTRL: nxt_q.ext_en = wmerged[sube_pkg::CTRL_EXT_EN];
            sube_pkg::REG_INSTR: begin
               nxt_q.instr = wmerged[15:0];
               if (new_legal) begin
                  nxt_q.ph = sube_pkg::PH_ONE;
               end else begin
                  nxt_q.reject = 1'b1;
               end
            end
            sube_pkg::REG_ACC: nxt_q.acc = wmerged[7:0];
            sube_pkg::REG_BANK: nxt_q.bank = wmerged[3:0];
            sube_pkg::REG_STATUS: begin
               if (wmerged[sube_pkg::ST_REJECT]) begin
                  nxt_q.reject = 1'b0;
               end
            end
            sube_pkg::REG_IDX_BASE: nxt_q.idx_base = wmerged[11:0];
            sube_pkg::REG_RAM_ADDR: nxt_q.ram_addr = wmerged[11:0];
            sube_pkg::REG_RAM_DATA: begin
               ram_we = 1'b1;
               ram_waddr = q_ff.ram_addr;
               ram_wdata = wmerged[7:0];
            end
            default: nxt_q.bresp = sube_pkg::RESP_SLVERR;
         endcase
      end
      // Four phases of one instruction cycle
      unique case (q_ff.ph)
         sube_pkg::PH_IDLE: begin
            // A legal instruction word written this cycle starts phase one
            if (wr_go && q_ff.awaddr == sube_pkg::REG_INSTR && new_legal) begin
               nxt_q.ph = sube_pkg::PH_ONE;
            end else begin
               nxt_q.ph = sube_pkg::PH_IDLE;
            end
         end
         sube_pkg::PH_ONE: begin
            nxt_q.ex_addr = ex_addr_c;
            nxt_q.ph = sube_pkg::PH_TWO;
         end
         sube_pkg::PH_TWO: begin
            nxt_q.opnd = is_lit ? f_addr : ram_rdata;
            nxt_q.ph = sube_pkg::PH_THREE;
         end
         sube_pkg::PH_THREE: begin
            nxt_q.res = diff9[7:0];
            nxt_q.res_flags = flags_c;
            nxt_q.ph = sube_pkg::PH_FOUR;
         end
         sube_pkg::PH_FOUR: begin
            nxt_q.flags = q_ff.res_flags;
            if (is_file && dest_file) begin
               ram_we = 1'b1;
            end else begin
               nxt_q.acc = q_ff.res;
            end
            nxt_q.ph = sube_pkg::PH_IDLE;
         end
         default: nxt_q.ph = sube_pkg::PH_IDLE;
      endcase
      if (q_ff.rvalid && s_axi_rready) begin
         nxt_q.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_q.rvalid = 1'b1;
         nxt_q.rdata = rd_ok ? rd_word : 32'h0000_0000;
         nxt_q.rresp = rd_ok ? sube_pkg::RESP_OKAY : sube_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q_ff <= sube_pkg::STATE_RST;
      end else begin
         q_ff <= nxt_q;
      end
   end

   sube_file_ram u_ram (
      .clk(clk),
      .reset(reset),
      .rd_addr(ram_raddr),
      .rd_data(ram_rdata),
      .we(ram_we),
      .wr_addr(ram_waddr),
      .wr_data(ram_wdata)
   );

   assign s_axi_awready = ~q_ff.aw_held;
   assign s_axi_wready = ~q_ff.w_held;
   assign s_axi_bvalid = q_ff.bvalid;
   assign s_axi_bresp = q_ff.bresp;
   assign s_axi_arready = ~q_ff.rvalid;
   assign s_axi_rvalid = q_ff.rvalid;
   assign s_axi_rdata = q_ff.rdata;
   assign s_axi_rresp = q_ff.rresp;
   assign busy = (q_ff.ph != sube_pkg::PH_IDLE);
   assign phase_one = (q_ff.ph == sube_pkg::PH_ONE);

   // Checks on the execution path
   AST_LIT_RESULT: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph == sube_pkg::PH_ONE && is_lit)
      |-> ##4 (q_ff.acc == 8'($past(q_ff.instr[7:0], 4) - $past(q_ff.acc, 4))))
      else $error("literal subtract left a wrong accumulator");

   AST_FILE_DIFF: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph == sube_pkg::PH_TWO && is_file)
      |-> ##2 (q_ff.res == 8'($past(ram_rdata, 2) - $past(q_ff.acc, 2))))
      else $error("file subtract difference is wrong");

   AST_DEST_ACC: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph == sube_pkg::PH_FOUR && is_file && !dest_file)
      |-> !ram_we ##1 (q_ff.acc == $past(q_ff.res)))
      else $error("accumulator destination not honoured");

   AST_DEST_FILE: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph == sube_pkg::PH_FOUR && is_file && dest_file)
      |-> (ram_we && ram_waddr == q_ff.ex_addr && ram_wdata == q_ff.res) ##1 (q_ff.acc == $past(q_ff.acc)))
      else $error("file destination not honoured");

   AST_ACCESS_BANK: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph == sube_pkg::PH_ONE && is_file && access_sel && !indexed)
      |=> (q_ff.ex_addr[11:8] == (($past(f_addr) <= sube_pkg::ACCESS_LIMIT)
          ? sube_pkg::ACCESS_LO_BANK : sube_pkg::ACCESS_HI_BANK)))
      else $error("access bank mapping is wrong");

   AST_BANK_SELECT: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph == sube_pkg::PH_ONE && is_file && !access_sel)
      |=> (q_ff.ex_addr == {$past(q_ff.bank), $past(f_addr)}))
      else $error("bank select not applied");

   AST_INDEXED: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph == sube_pkg::PH_ONE && indexed)
      |=> (q_ff.ex_addr == 12'($past(q_ff.idx_base) + $past(f_addr))))
      else $error("indexed offset address is wrong");

   AST_FOUR_PHASES: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph == sube_pkg::PH_ONE)
      |=> (q_ff.ph == sube_pkg::PH_TWO) ##1 (q_ff.ph == sube_pkg::PH_THREE)
          ##1 (q_ff.ph == sube_pkg::PH_FOUR) ##1 (q_ff.ph == sube_pkg::PH_IDLE))
      else $error("instruction did not take four phases");

   AST_FILE_READ: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph == sube_pkg::PH_ONE && is_file) |-> (ram_raddr == ex_addr_c) ##1 (q_ff.ph == sube_pkg::PH_TWO))
      else $error("operand not read in phase two");

   AST_CARRY_SIGN: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph == sube_pkg::PH_FOUR)
      |=> (q_ff.flags.n == $past(q_ff.res[7]) && q_ff.flags.c == ($past(q_ff.opnd) >= $past(q_ff.acc))))
      else $error("carry or negative flag wrong");

   AST_ZERO: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph == sube_pkg::PH_FOUR && q_ff.res == 8'h00) |=> (q_ff.flags.z && q_ff.flags.c))
      else $error("zero result flags wrong");

   AST_POSITIVE: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph == sube_pkg::PH_FOUR && q_ff.opnd > q_ff.acc && !q_ff.res[7])
      |=> (q_ff.flags.c && !q_ff.flags.z && !q_ff.flags.n))
      else $error("positive result flags wrong");

   AST_OVF_NIBBLE: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph == sube_pkg::PH_FOUR)
      |=> (q_ff.flags.signed_overflow_flag
          == (($past(q_ff.opnd[7]) != $past(q_ff.acc[7])) && ($past(q_ff.res[7]) != $past(q_ff.opnd[7])))
          && q_ff.flags.nibble_borrow_flag == ($past(q_ff.opnd[3:0]) >= $past(q_ff.acc[3:0]))))
      else $error("overflow or nibble borrow flag wrong");

   AST_LEGAL_START: assert property (@(posedge clk) disable iff (reset)
      (wr_go && q_ff.awaddr == sube_pkg::REG_INSTR && new_legal) |=> (q_ff.ph == sube_pkg::PH_ONE))
      else $error("legal instruction word did not start");

   AST_ILLEGAL_IDLE: assert property (@(posedge clk) disable iff (reset)
      (wr_go && q_ff.awaddr == sube_pkg::REG_INSTR && !new_legal) |=> (q_ff.ph == sube_pkg::PH_IDLE && q_ff.reject))
      else $error("illegal instruction word was not refused");

   AST_ONE_PULSE: assert property (@(posedge clk) disable iff (reset)
      phase_one |=> !phase_one)
      else $error("decode phase lasted more than one cycle");

   AST_LIT_NO_RAM: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph == sube_pkg::PH_FOUR && is_lit) |-> !ram_we)
      else $error("literal subtract wrote file memory");

   AST_ACC_EARLY: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph == sube_pkg::PH_ONE || q_ff.ph == sube_pkg::PH_TWO || q_ff.ph == sube_pkg::PH_THREE)
      |=> $stable(q_ff.acc))
      else $error("accumulator changed before the write phase");

   AST_FLAGS_HOLD: assert property (@(posedge clk) disable iff (reset)
      (q_ff.ph != sube_pkg::PH_FOUR) |=> $stable(q_ff.flags))
      else $error("status flags changed outside the write phase");

   AST_RAM_WRITE_PHASE: assert property (@(posedge clk) disable iff (reset)
      (ram_we && q_ff.ph != sube_pkg::PH_IDLE) |-> (q_ff.ph == sube_pkg::PH_FOUR && is_file && dest_file))
      else $error("file memory written outside a file destination");
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the subtract execution core, with a behavioural model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] awa = 8'h00;
   logic awv = 1'b0;
   logic awr;
   logic [31:0] wd = 32'h00000000;
   logic [3:0] ws = 4'hF;
   logic wv = 1'b0;
   logic wr_rdy;
   logic [1:0] br;
   logic bv;
   logic brd = 1'b0;
   logic [7:0] ara = 8'h00;
   logic arv = 1'b0;
   logic arr;
   logic [31:0] rdt;
   logic [1:0] rr;
   logic rv;
   logic rrd = 1'b0;
   logic busy;
   logic phase_one;
   logic [31:0] rdat;
   logic [1:0] lresp;
   int miscompares = 0;
   int tests_run = 0;
   int cyc = 0;
   int bcnt = 0;
   int pcnt = 0;

   sube_core DUT (.clk(clk), .reset(reset), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd), .busy(busy),
      .phase_one(phase_one));

   always #12.5 clk = ~clk;

   // Counts busy cycles and decode pulses of each instruction
   always @(posedge clk) begin
      cyc++;
      if (busy === 1'b1) bcnt++;
      if (phase_one === 1'b1) pcnt++;
      if (cyc > 20000) begin
         miscompares++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
      logic done;
      done = 1'b0;
      awa <= ad;
      wd <= dt;
      awv <= 1'b1;
      wv <= 1'b1;
      brd <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (awv && awr === 1'b1) awv <= 1'b0;
         if (wv && wr_rdy === 1'b1) wv <= 1'b0;
         if (bv === 1'b1) begin
            lresp = br;
            brd <= 1'b0;
            done = 1'b1;
         end
      end
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] ad);
      logic done;
      done = 1'b0;
      ara <= ad;
      arv <= 1'b1;
      rrd <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (arv && arr === 1'b1) arv <= 1'b0;
         if (rv === 1'b1) begin
            rdat = rdt;
            lresp = rr;
            rrd <= 1'b0;
            done = 1'b1;
         end
      end
      @(posedge clk);
   endtask

   // Model: flags (negative, overflow, zero, nibble, carry) shifted by 8, or-ed with the difference x - y
   function automatic int subm(input int x, input int y);
      int r;
      int f;
      r = (x - y) & 255;
      f = int'(x >= y) | (int'((x & 15) >= (y & 15)) << 1) | (int'(r == 0) << 2);
      f = f | (int'(((x ^ y) & (x ^ r) & 128) != 0) << 3) | ((r >> 7) << 4);
      return (f << 8) | r;
   endfunction

   initial begin
      int acc, k, f, d, a, bnk, ext, idx, ea, v, ex, lit, ins, st;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      void'($urandom(32'h0030350f));
      rd(sube_pkg::REG_ACC);
      `CHK("acc reset", 32'h0, rdat)
      rd(sube_pkg::REG_STATUS);
      `CHK("status reset", 32'h0, rdat)
      // Illegal word is refused and does not run
      bcnt = 0;
      wr(sube_pkg::REG_INSTR, 32'h0000FFFF);
      repeat (8) @(posedge clk);
      `CHK("busy refused", 0, bcnt)
      rd(sube_pkg::REG_STATUS);
      `CHK("reject", 32'h40, rdat)
      wr(sube_pkg::REG_STATUS, 32'h00000040);
      rd(sube_pkg::REG_STATUS);
      `CHK("reject clr", 32'h0, rdat)
      rd(8'h20);
      `CHK("unmapped rresp", sube_pkg::RESP_SLVERR, lresp)
      `CHK("unmapped rdata", 32'h0, rdat)
      wr(8'h24, 32'h12345678);
      `CHK("unmapped bresp", sube_pkg::RESP_SLVERR, lresp)
      for (int i = 0; i < 40; i++) begin
         lit = $urandom % 2;
         acc = $urandom % 256;
         wr(sube_pkg::REG_ACC, acc);
         if (lit) begin
            k = $urandom % 256;
            ins = 16'h0800 | k;
            ex = subm(k, acc);
         end else begin
            bnk = $urandom % 16;
            ext = $urandom % 2;
            idx = $urandom % 4096;
            f = ($urandom % 2) ? $urandom % 96 : $urandom % 256;
            d = $urandom % 2;
            a = $urandom % 2;
            wr(sube_pkg::REG_BANK, bnk);
            wr(sube_pkg::REG_CTRL, ext);
            wr(sube_pkg::REG_IDX_BASE, idx);
            if (a) ea = (bnk << 8) | f;
            else if (ext && f <= 95) ea = (idx + f) & 12'hFFF;
            else ea = (f <= 95) ? f : 12'hF00 | f;
            v = $urandom % 256;
            wr(sube_pkg::REG_RAM_ADDR, ea);
            wr(sube_pkg::REG_RAM_DATA, v);
            ex = subm(v, acc);
            ins = 16'h5C00 | (d << 9) | (a << 8) | f;
         end
         bcnt = 0;
         pcnt = 0;
         wr(sube_pkg::REG_INSTR, ins);
         repeat (8) @(posedge clk);
         `CHK("busy cycles", 4, bcnt)
         `CHK("decode pulses", 1, pcnt)
         rd(sube_pkg::REG_ACC);
         if (lit) `CHK("acc lit", ex & 255, rdat)
         else if (!d) `CHK("acc file", ex & 255, rdat)
         else `CHK("acc kept", acc, rdat)
         rd(sube_pkg::REG_STATUS);
         st = ex >> 8;
         `CHK("status", st, rdat)
         if ((ex & 255) == 0) `CHK("zero c z", 2'b11, {rdat[2], rdat[0]})
         else if ((ex & 128) == 0 && (st & 1)) `CHK("pos n z c", 3'b001, {rdat[4], rdat[2], rdat[0]})
         `CHK("overflow nibble", {st[3], st[1]}, {rdat[3], rdat[1]})
         if (!lit) begin
            wr(sube_pkg::REG_RAM_ADDR, ea);
            rd(sube_pkg::REG_RAM_DATA);
            if (!d) `CHK("ram kept", v, rdat)
            else if (a) `CHK("ram bank", ex & 255, rdat)
            else if (ext && f <= 95) `CHK("ram indexed", ex & 255, rdat)
            else `CHK("ram access", ex & 255, rdat)
         end
      end
      end_sim();
   end
endmodule
`default_nettype wire
